// *** verilog/tec_defs.svh ***
`ifndef TEC_DEFS_SVH
`define TEC_DEFS_SVH

// ==========================================================================
// register offsets
`define OFS_SYSTEM_SETTING   8'h00
`define OFS_HEAT_ILIMIT      8'h01
`define OFS_COOL_ILIMIT      8'h02
`define OFS_HEAT_VLIMIT      8'h03
`define OFS_COOL_VLIMIT      8'h04
`define OFS_SECONDARY_LIMITS 8'h05

// ==========================================================================
// reset values
`define RST_SYSTEM_SETTING   8'h10
`define RST_LIMIT            8'h00

// ==========================================================================
// field positions
`define SYS_POWER_ON_BIT     0
`define SYS_SS_SEL_LSB       2
`define SYS_SS_SEL_MSB       3
`define SYS_DISCH_SEL_BIT    4
`define LIM_ENABLE_BIT       7
`define VLIM_OVP_BIT         6
`define LIM_VALUE_MSB        5
`define SYS_WRITE_MASK       8'h1d
`define HEAT_VLIM_MASK       8'hff
`define LIM_OTHER_MASK       8'hbf

// ==========================================================================
// timing
`define CLK_MHZ              100
`define DISCH_SHORT_MS       35
`define DISCH_LONG_MS        70
`define DISCH_SHORT_CYC      (`DISCH_SHORT_MS * `CLK_MHZ * 1000)
`define DISCH_LONG_CYC       (`DISCH_LONG_MS * `CLK_MHZ * 1000)
`define BUCK_WAIT_US         100
`define BUCK_WAIT_CYC        (`BUCK_WAIT_US * `CLK_MHZ)
`define EN_OFF_DELAY_US      10
`define EN_OFF_DELAY_CYC     (`EN_OFF_DELAY_US * `CLK_MHZ)
`define HICCUP_OFF_MS        10
`define HICCUP_OFF_CYC       (`HICCUP_OFF_MS * `CLK_MHZ * 1000)
`define SYNC_WINDOW_US       2
`define SYNC_WINDOW_CYC      (`SYNC_WINDOW_US * `CLK_MHZ)
`define OSC_KHZ              1000
`define OSC_HALF_CYC         (`CLK_MHZ * 1000 / `OSC_KHZ / 2)

`endif

// *** verilog/tec_pkg.sv ***
package tec_pkg;

  // ==========================================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE      = 6'h01,
    ST_DISCHARGE = 6'h02,
    ST_WAIT_LOW  = 6'h04,
    ST_RAMP1     = 6'h08,
    ST_RAMP2     = 6'h10,
    ST_HICCUP    = 6'h20
  } seq_state_t;

endpackage : tec_pkg

// *** verilog/tec_power_stage_sequencer.sv ***
`timescale 1ns/100ps
`include "tec_defs.svh"

// ==========================================================================
// three-stage input filter: output moves once stages two and three agree
module tec_input_filter #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      q_o <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
          q_o[i] <= s3_q[i];
      end
    end
  end
endmodule : tec_input_filter

// Behaviour
// - stage on needs supply, enable, shutdown, on-bit
// - shutdown low turns stage off immediately
// - enable low turns off after delay
// - discharge 35 or 70 ms first
// - first ramp waits for rails low
// - ramp to mid voltage, then regulate
// - soft-start discharge multiple 1x to 8x
// - static high enable uses internal oscillator
// - align internal clock to external edge in regulation
// - six-bit voltage limit fields
// - over voltage limit regulates buck to limit
// - secondary voltage limit: stop, enter hiccup
// - voltage limit enable and overvoltage bits
// - six-bit current limit fields
// - secondary limits: four two-bit fields
// - linear first limit holds linear output
// - linear second limit: fast off, hiccup
// - buck limit persisting 100 us: hiccup
// - discharge select: 0 is 70, 1 is 35
// - soft-start select is bits 3:2
// - discharge path on through hiccup off
// - bit 7 enables current limit
module tec_power_stage_sequencer
  import tec_pkg::*;
#(
  parameter int unsigned DISCH_SHORT_CYC = `DISCH_SHORT_CYC,
  parameter int unsigned DISCH_LONG_CYC  = `DISCH_LONG_CYC,
  parameter int unsigned BUCK_WAIT_CYC   = `BUCK_WAIT_CYC,
  parameter int unsigned HICCUP_OFF_CYC  = `HICCUP_OFF_CYC,
  parameter int unsigned EN_OFF_CYC      = `EN_OFF_DELAY_CYC,
  parameter int unsigned SYNC_WIN_CYC    = `SYNC_WINDOW_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_sync_clk_i,
  input  wire logic       en_sync_i,
  input  wire logic       shutdown_pin_i,
  input  wire logic       uvlo_ok_i,
  input  wire logic       rails_low_i,
  input  wire logic       ss_at_mid_i,
  input  wire logic       tec_heating_i,
  input  wire logic       tec_over_vlimit_i,
  input  wire logic       tec_over_vlimit2_i,
  input  wire logic       linear_ilim1_i,
  input  wire logic       linear_ilim2_i,
  input  wire logic       buck_ilim_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            power_stage_on_o,
  output logic            discharge_o,
  output logic            ss_ramp_o,
  output logic            regulate_o,
  output logic            hiccup_o,
  output logic            fast_off_o,
  output logic            vlimit_regulate_o,
  output logic            linear_hold_o,
  output logic            pwm_clk_o,
  output logic            pwm_sync_locked_o,
  output logic      [1:0] ss_discharge_mult_o,
  output logic      [5:0] active_vlimit_value_o,
  output logic      [5:0] active_ilimit_value_o,
  output logic      [7:0] secondary_limits_o,
  output logic            input_overvoltage_enable_o
);

  if (DISCH_SHORT_CYC < 1 || DISCH_LONG_CYC < 1 || BUCK_WAIT_CYC < 1 ||
      HICCUP_OFF_CYC < 1 || EN_OFF_CYC < 1 || SYNC_WIN_CYC < 2)
    $error("timing parameters must be at least one cycle");

  // ==========================================================================
  // link domain: edge toggle on the sync clock
  logic link_rst1_q;
  logic link_rst2_q;
  logic link_tog_q;

  // reset must reach the link side even while the sync clock stands still
  always_ff @(posedge en_sync_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link_rst1_q <= 1'b0;
      link_rst2_q <= 1'b0;
    end
    else
    begin
      link_rst1_q <= 1'b1;
      link_rst2_q <= link_rst1_q;
    end
  end

  always_ff @(posedge en_sync_clk_i)
  begin
    if (!link_rst2_q)
      link_tog_q <= 1'b0;
    else
      link_tog_q <= ~link_tog_q;
  end

  // ==========================================================================
  // input conditioning
  logic [12:0] raw_in;
  logic [12:0] flt;
  assign raw_in = {link_tog_q, en_sync_i, shutdown_pin_i, uvlo_ok_i, rails_low_i,
                   ss_at_mid_i, tec_heating_i, tec_over_vlimit_i, tec_over_vlimit2_i,
                   linear_ilim1_i, linear_ilim2_i, buck_ilim_i, 1'b0};

  tec_input_filter #(.W(13)) u_filter (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (raw_in),
    .q_o     (flt)
  );

  logic tog_s, en_s, sd_s, uvlo_s, low_s, mid_s, heat_s;
  logic ovl_s, ovl2_s, lin1_s, lin2_s, buck_s;
  assign {tog_s, en_s, sd_s, uvlo_s, low_s, mid_s, heat_s,
          ovl_s, ovl2_s, lin1_s, lin2_s, buck_s} = flt[12:1];

  // ==========================================================================
  // registers
  logic [7:0] sys_q, heat_i_q, cool_i_q, heat_v_q, cool_v_q, sec_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sys_q    <= `RST_SYSTEM_SETTING;
      heat_i_q <= `RST_LIMIT;
      cool_i_q <= `RST_LIMIT;
      heat_v_q <= `RST_LIMIT;
      cool_v_q <= `RST_LIMIT;
      sec_q    <= `RST_LIMIT;
    end
    else if (reg_wr_i)
    begin
      // refresh bit is not stored: nothing latched here to refresh
      case (reg_addr_i)
        `OFS_SYSTEM_SETTING:   sys_q    <= reg_wdata_i & `SYS_WRITE_MASK;
        `OFS_HEAT_ILIMIT:      heat_i_q <= reg_wdata_i & `LIM_OTHER_MASK;
        `OFS_COOL_ILIMIT:      cool_i_q <= reg_wdata_i & `LIM_OTHER_MASK;
        `OFS_HEAT_VLIMIT:      heat_v_q <= reg_wdata_i & `HEAT_VLIM_MASK;
        `OFS_COOL_VLIMIT:      cool_v_q <= reg_wdata_i & `LIM_OTHER_MASK;
        `OFS_SECONDARY_LIMITS: sec_q    <= reg_wdata_i;
        default:               sys_q    <= sys_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `OFS_SYSTEM_SETTING:   reg_rdata_o <= sys_q;
        `OFS_HEAT_ILIMIT:      reg_rdata_o <= heat_i_q;
        `OFS_COOL_ILIMIT:      reg_rdata_o <= cool_i_q;
        `OFS_HEAT_VLIMIT:      reg_rdata_o <= heat_v_q;
        `OFS_COOL_VLIMIT:      reg_rdata_o <= cool_v_q;
        `OFS_SECONDARY_LIMITS: reg_rdata_o <= sec_q;
        default:               reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // sync clock presence
  logic        tog_prev_q;
  logic        ext_edge;
  logic [31:0] sync_age_q;
  logic        sync_seen;
  assign ext_edge  = tog_s ^ tog_prev_q;
  assign sync_seen = sync_age_q < SYNC_WIN_CYC;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tog_prev_q <= 1'b0;
      sync_age_q <= SYNC_WIN_CYC;
    end
    else
    begin
      tog_prev_q <= tog_s;
      if (ext_edge)
        sync_age_q <= 32'd0;
      else if (sync_seen)
        sync_age_q <= sync_age_q + 32'd1;
    end
  end

  // ==========================================================================
  // enable with turn-off delay
  logic        en_raw;
  logic [31:0] en_off_cnt_q;
  logic        en_del_q;
  logic        en_ok;
  assign en_raw = en_s | sync_seen;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      en_off_cnt_q <= 32'd0;
      en_del_q     <= 1'b0;
    end
    else if (en_raw)
    begin
      en_off_cnt_q <= 32'd0;
      en_del_q     <= 1'b1;
    end
    else if (en_del_q)
    begin
      en_off_cnt_q <= en_off_cnt_q + 32'd1;
      if (en_off_cnt_q == EN_OFF_CYC - 32'd1)
        en_del_q <= 1'b0;
    end
  end

  // shutdown and supply act at once; only the enable pin is delayed
  assign en_ok = uvlo_s & sd_s & sys_q[`SYS_POWER_ON_BIT] & en_del_q;

  // ==========================================================================
  // sequencer
  seq_state_t  state_q, state_d;
  logic [31:0] tmr_q;
  logic [31:0] buck_cnt_q;
  logic [31:0] disch_len;
  logic        running;
  logic        fast_fault;
  logic        buck_fault;

  assign disch_len  = sys_q[`SYS_DISCH_SEL_BIT] ? DISCH_SHORT_CYC : DISCH_LONG_CYC;
  assign running    = (state_q == ST_RAMP1) || (state_q == ST_RAMP2);
  assign fast_fault = lin2_s | ovl2_s;
  // slow recovery window for the buck: hiccup only if limit persists
  assign buck_fault = buck_s && (buck_cnt_q == BUCK_WAIT_CYC - 32'd1);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (en_ok)
          state_d = ST_DISCHARGE;
      ST_DISCHARGE:
        if (!en_ok)
          state_d = ST_IDLE;
        else if (tmr_q == disch_len - 32'd1)
          state_d = ST_WAIT_LOW;
      ST_WAIT_LOW:
        if (!en_ok)
          state_d = ST_IDLE;
        else if (low_s)
          state_d = ST_RAMP1;
      ST_RAMP1:
        if (!en_ok)
          state_d = ST_IDLE;
        else if (fast_fault || buck_fault)
          state_d = ST_HICCUP;
        else if (mid_s)
          state_d = ST_RAMP2;
      ST_RAMP2:
        if (!en_ok)
          state_d = ST_IDLE;
        else if (fast_fault || buck_fault)
          state_d = ST_HICCUP;
      ST_HICCUP:
        if (!en_ok)
          state_d = ST_IDLE;
        else if (tmr_q == HICCUP_OFF_CYC - 32'd1)
          state_d = ST_DISCHARGE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || state_d != state_q)
      tmr_q <= 32'd0;
    else
      tmr_q <= tmr_q + 32'd1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !running || !buck_s)
      buck_cnt_q <= 32'd0;
    else
      buck_cnt_q <= buck_cnt_q + 32'd1;
  end

  // ==========================================================================
  // stage outputs follow the next state so they line up with state_q
  logic lim_v_en;
  logic lim_i_en;
  logic run_d;
  assign lim_v_en = heat_s ? heat_v_q[`LIM_ENABLE_BIT] : cool_v_q[`LIM_ENABLE_BIT];
  assign lim_i_en = heat_s ? heat_i_q[`LIM_ENABLE_BIT] : cool_i_q[`LIM_ENABLE_BIT];
  assign run_d    = (state_d == ST_RAMP1) || (state_d == ST_RAMP2);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      power_stage_on_o  <= 1'b0;
      discharge_o       <= 1'b0;
      ss_ramp_o         <= 1'b0;
      regulate_o        <= 1'b0;
      hiccup_o          <= 1'b0;
      fast_off_o        <= 1'b0;
      vlimit_regulate_o <= 1'b0;
      linear_hold_o     <= 1'b0;
    end
    else
    begin
      power_stage_on_o  <= state_d != ST_IDLE;
      discharge_o       <= (state_d == ST_DISCHARGE) || (state_d == ST_WAIT_LOW) ||
                           (state_d == ST_HICCUP);
      ss_ramp_o         <= state_d == ST_RAMP1;
      regulate_o        <= state_d == ST_RAMP2;
      hiccup_o          <= state_d == ST_HICCUP;
      fast_off_o        <= running && state_d == ST_HICCUP && fast_fault;
      vlimit_regulate_o <= run_d && lim_v_en && ovl_s;
      linear_hold_o     <= run_d && lim_i_en && lin1_s;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ss_discharge_mult_o        <= 2'h0;
      active_vlimit_value_o      <= 6'h00;
      active_ilimit_value_o      <= 6'h00;
      secondary_limits_o         <= 8'h00;
      input_overvoltage_enable_o <= 1'b0;
    end
    else
    begin
      ss_discharge_mult_o        <= sys_q[`SYS_SS_SEL_MSB:`SYS_SS_SEL_LSB];
      active_vlimit_value_o      <= heat_s ? heat_v_q[`LIM_VALUE_MSB:0]
                                           : cool_v_q[`LIM_VALUE_MSB:0];
      active_ilimit_value_o      <= heat_s ? heat_i_q[`LIM_VALUE_MSB:0]
                                           : cool_i_q[`LIM_VALUE_MSB:0];
      secondary_limits_o         <= sec_q;
      input_overvoltage_enable_o <= heat_v_q[`VLIM_OVP_BIT];
    end
  end

  // ==========================================================================
  // switching clock: internal divider, phase pulled to the external edge
  logic [7:0] pwm_cnt_q;
  logic       lock;
  // lock waits for regulation so start-up never sees a phase jump
  assign lock = sync_seen && (state_q == ST_RAMP2);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pwm_cnt_q         <= 8'h00;
      pwm_clk_o         <= 1'b0;
      pwm_sync_locked_o <= 1'b0;
    end
    else
    begin
      pwm_sync_locked_o <= lock;
      if (lock && ext_edge && !tog_s)
      begin
        pwm_cnt_q <= 8'h00;
        pwm_clk_o <= 1'b1;
      end
      else if (pwm_cnt_q == 8'(`OSC_HALF_CYC - 1))
      begin
        pwm_cnt_q <= 8'h00;
        pwm_clk_o <= ~pwm_clk_o;
      end
      else
        pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_sd_stage_off: assert property (!sd_s |=> !power_stage_on_o)
    else $error("stage on while shutdown low");
  a_start_all_ok: assert property ($rose(power_stage_on_o) |-> $past(en_ok))
    else $error("stage started without all enables");
  a_discharge_first: assert property ($rose(ss_ramp_o) |-> $past(discharge_o))
    else $error("ramp began without discharge");
  a_ramp_rails_low: assert property ($rose(ss_ramp_o) && !$past(regulate_o)
                                     |-> $past(low_s))
    else $error("ramp began with rails high");
  a_mid_to_reg: assert property (state_q == ST_RAMP1 && mid_s && en_ok && !fast_fault
                                 && !buck_fault |=> regulate_o && !ss_ramp_o)
    else $error("mid voltage did not start regulation");
  a_disch_length: assert property (state_q == ST_DISCHARGE && state_d == ST_WAIT_LOW
                                   |-> tmr_q == disch_len - 32'd1)
    else $error("discharge interval wrong");
  a_linear_fast_off: assert property (running && lin2_s && en_ok
                                      |=> hiccup_o && fast_off_o)
    else $error("linear second limit missed");
  a_buck_no_early: assert property (running && buck_s && en_ok && !fast_fault
                                    && buck_cnt_q < BUCK_WAIT_CYC - 32'd1
                                    |=> !hiccup_o)
    else $error("buck hiccup before wait");
  a_hiccup_discharge: assert property (hiccup_o |-> discharge_o && !regulate_o)
    else $error("discharge off in hiccup");
  a_en_delay_hold: assert property ($fell(en_raw) && en_del_q |=> en_del_q)
    else $error("enable dropped without delay");
  a_vlimit_reg: assert property (vlimit_regulate_o |-> regulate_o || ss_ramp_o)
    else $error("voltage limit outside running");
  a_loss_aborts: assert property (!en_ok && state_q != ST_IDLE |=> state_q == ST_IDLE)
    else $error("enable loss did not abort");

endmodule : tec_power_stage_sequencer

// *** bench/tec_sync_source.sv ***
`timescale 1ns/100ps

// ==========================================================================
// host-side source on the enable/sync pin: a static level or a burst clock
module tec_sync_source (
  input  wire logic run_i,
  input  wire logic level_i,
  output logic      pin_o
);
  logic lclk = 1'b0;

  // odd start offset staggers the burst clock, but every fifth toggle still lands on a system clock rising edge
  initial
  begin
    #7;
    forever #24 lclk = ~lclk;
  end

  // rate is scaled for simulation; a real host stays inside 1 to 1.5 MHz
  // the pin rests at the host level between bursts, never mid-toggle
  assign pin_o = run_i ? lclk : level_i;
endmodule : tec_sync_source

// *** bench/tec_power_stage_sequencer_tb.sv ***
`timescale 1ns/100ps

module tec_power_stage_sequencer_tb
  import tec_pkg::*;
;
  localparam int S_ON = 0, S_DIS = 1, S_RAMP = 2, S_REG = 3, S_HIC = 4;
  localparam logic [7:0] RST_V [7] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK_V [7] = '{8'h1d, 8'hbf, 8'hbf, 8'hff, 8'hbf, 8'hff, 8'h00};

  logic       clk_sys_i = 1'b0;
  logic       rst_n_i, en_lvl, sync_run, en_pin, shutdown_pin_i, uvlo_ok_i;
  logic       rails_low_i, ss_at_mid_i, tec_heating_i, tec_over_vlimit_i;
  logic       tec_over_vlimit2_i, linear_ilim1_i, linear_ilim2_i, buck_ilim_i;
  logic       reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, secondary_limits_o;
  logic       power_stage_on_o, discharge_o, ss_ramp_o, regulate_o, hiccup_o;
  logic       fast_off_o, vlimit_regulate_o, linear_hold_o, pwm_clk_o;
  logic       pwm_sync_locked_o, input_overvoltage_enable_o;
  logic [1:0] ss_discharge_mult_o;
  logic [5:0] active_vlimit_value_o, active_ilimit_value_o;
  int         failures = 0, comparisons = 0, fast_cnt = 0, bad_hic = 0;
  int         n, t, f0;
  logic       p;

  always #5 clk_sys_i = ~clk_sys_i;

  // ==========================================================================
  // event counters: fast-off is a one-cycle pulse, easy to miss by polling
  always @(posedge clk_sys_i)
  begin
    if (fast_off_o === 1'b1) fast_cnt <= fast_cnt + 1;
    if (hiccup_o === 1'b1 && discharge_o !== 1'b1) bad_hic <= bad_hic + 1;
  end

  tec_sync_source host_sync (.run_i(sync_run), .level_i(en_lvl), .pin_o(en_pin));

  tec_power_stage_sequencer #(
    .DISCH_SHORT_CYC(20), .DISCH_LONG_CYC(40), .BUCK_WAIT_CYC(10),
    .HICCUP_OFF_CYC(30), .EN_OFF_CYC(8)
  ) uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .en_sync_clk_i(en_pin), .en_sync_i(en_pin),
    .shutdown_pin_i(shutdown_pin_i), .uvlo_ok_i(uvlo_ok_i), .rails_low_i(rails_low_i),
    .ss_at_mid_i(ss_at_mid_i), .tec_heating_i(tec_heating_i),
    .tec_over_vlimit_i(tec_over_vlimit_i), .tec_over_vlimit2_i(tec_over_vlimit2_i),
    .linear_ilim1_i(linear_ilim1_i), .linear_ilim2_i(linear_ilim2_i),
    .buck_ilim_i(buck_ilim_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .power_stage_on_o(power_stage_on_o), .discharge_o(discharge_o), .ss_ramp_o(ss_ramp_o),
    .regulate_o(regulate_o), .hiccup_o(hiccup_o), .fast_off_o(fast_off_o),
    .vlimit_regulate_o(vlimit_regulate_o), .linear_hold_o(linear_hold_o),
    .pwm_clk_o(pwm_clk_o), .pwm_sync_locked_o(pwm_sync_locked_o),
    .ss_discharge_mult_o(ss_discharge_mult_o), .active_vlimit_value_o(active_vlimit_value_o),
    .active_ilimit_value_o(active_ilimit_value_o), .secondary_limits_o(secondary_limits_o),
    .input_overvoltage_enable_o(input_overvoltage_enable_o)
  );

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic sig(input int s);
    case (s)
      S_ON:    sig = power_stage_on_o;
      S_DIS:   sig = discharge_o;
      S_RAMP:  sig = ss_ramp_o;
      S_REG:   sig = regulate_o;
      default: sig = hiccup_o;
    endcase
  endfunction : sig

  // bounded wait; returns the cycles spent, caller checks the outcome
  task automatic wait_for(input int s, input logic v, input int max, output int cnt);
    #1;
    cnt = 0;
    while (sig(s) !== v && cnt < max)
    begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
    end
  endtask : wait_for

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask : rd

  task automatic set_fault(input int k, input logic v);
    @(posedge clk_sys_i);
    if (k == 0) tec_over_vlimit2_i <= v;
    else if (k == 1) linear_ilim2_i <= v;
    else buck_ilim_i <= v;
  endtask : set_fault

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // watchdog: the tests need about a thousand cycles
  initial
  begin
    #300000;
    failures++;
    end_sim();
  end

  // ==========================================================================
  // tests
  initial
  begin
    {rst_n_i, en_lvl, sync_run, ss_at_mid_i, tec_over_vlimit_i, tec_over_vlimit2_i} = '0;
    {linear_ilim1_i, linear_ilim2_i, buck_ilim_i, reg_wr_i, reg_rd_i} = '0;
    {shutdown_pin_i, uvlo_ok_i, rails_low_i, tec_heating_i} = 4'hf;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    tick(4);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) rd(i[7:0], RST_V[i]);
    for (int i = 0; i < 7; i++) wr(i[7:0], 8'hff);
    for (int i = 0; i < 7; i++) rd(i[7:0], MSK_V[i]);
    chk(power_stage_on_o, 1'b0);
    chk(secondary_limits_o, 8'hff);
    chk(input_overvoltage_enable_o, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h00, {4'h1, m[1:0], 2'b00});
      tick(2);
      chk(ss_discharge_mult_o, m[1:0]);
    end
    wr(8'h03, 8'h85);
    wr(8'h04, 8'h8a);
    wr(8'h01, 8'h81);
    wr(8'h02, 8'h82);
    tick(2);
    chk(input_overvoltage_enable_o, 1'b0);
    chk(active_vlimit_value_o, 6'h05);
    chk(active_ilimit_value_o, 6'h01);
    @(posedge clk_sys_i);
    tec_heating_i <= 1'b0;
    tick(8);
    chk(active_vlimit_value_o, 6'h0a);
    chk(active_ilimit_value_o, 6'h02);
    @(posedge clk_sys_i);
    tec_heating_i <= 1'b1;
    $display("test registers done");

    wr(8'h00, 8'h11);
    @(posedge clk_sys_i);
    en_lvl <= 1'b1;
    wait_for(S_ON, 1'b1, 20, n);
    chk(discharge_o, 1'b1);
    wait_for(S_DIS, 1'b0, 60, n);
    chk(n >= 20 && n <= 26, 1'b1);
    wait_for(S_RAMP, 1'b1, 10, n);
    chk(ss_ramp_o, 1'b1);
    @(posedge clk_sys_i);
    ss_at_mid_i <= 1'b1;
    wait_for(S_REG, 1'b1, 12, n);
    chk(regulate_o, 1'b1);
    p = pwm_clk_o;
    t = 0;
    repeat (200)
    begin
      @(posedge clk_sys_i);
      #1;
      if (pwm_clk_o !== p) t++;
      p = pwm_clk_o;
    end
    chk(t >= 3 && t <= 5, 1'b1);
    chk(pwm_sync_locked_o, 1'b0);
    @(posedge clk_sys_i);
    tec_over_vlimit_i <= 1'b1;
    linear_ilim1_i    <= 1'b1;
    tick(8);
    chk(vlimit_regulate_o, 1'b1);
    chk(linear_hold_o, 1'b1);
    wr(8'h03, 8'h05);
    wr(8'h01, 8'h01);
    tick(3);
    chk(vlimit_regulate_o, 1'b0);
    chk(linear_hold_o, 1'b0);
    @(posedge clk_sys_i);
    tec_over_vlimit_i <= 1'b0;
    linear_ilim1_i    <= 1'b0;
    $display("test start and limits done");

    // secondary voltage limit, then linear second current limit
    for (int k = 0; k < 2; k++)
    begin
      f0 = fast_cnt;
      set_fault(k, 1'b1);
      wait_for(S_HIC, 1'b1, 12, n);
      chk(hiccup_o, 1'b1);
      set_fault(k, 1'b0);
      wait_for(S_HIC, 1'b0, 60, n);
      chk(n >= 22 && n <= 32, 1'b1);
      chk(fast_cnt - f0 == 1, 1'b1);
      chk(discharge_o & power_stage_on_o, 1'b1);
      wait_for(S_REG, 1'b1, 60, n);
      chk(regulate_o, 1'b1);
    end
    f0 = fast_cnt;
    set_fault(2, 1'b1);
    tick(5);
    set_fault(2, 1'b0);
    tick(20);
    chk(hiccup_o, 1'b0);
    set_fault(2, 1'b1);
    wait_for(S_HIC, 1'b1, 25, n);
    chk(n >= 10, 1'b1);
    chk(fast_cnt - f0 == 0, 1'b1);
    set_fault(2, 1'b0);
    wait_for(S_REG, 1'b1, 120, n);
    chk(regulate_o, 1'b1);
    chk(bad_hic == 0, 1'b1);
    $display("test faults done");

    @(posedge clk_sys_i);
    sync_run <= 1'b1;
    tick(100);
    chk(pwm_sync_locked_o, 1'b1);
    chk(power_stage_on_o, 1'b1);
    @(posedge clk_sys_i);
    sync_run <= 1'b0;
    en_lvl   <= 1'b0;
    tick(8);
    chk(power_stage_on_o, 1'b1);
    // sync window at its default: last edge holds enable for up to 200 cycles
    wait_for(S_ON, 1'b0, 240, n);
    chk(power_stage_on_o, 1'b0);
    $display("test sync and enable delay done");

    wr(8'h00, 8'h01);
    @(posedge clk_sys_i);
    en_lvl <= 1'b1;
    wait_for(S_ON, 1'b1, 20, n);
    wait_for(S_DIS, 1'b0, 80, n);
    chk(n >= 40 && n <= 46, 1'b1);
    wait_for(S_REG, 1'b1, 12, n);
    @(posedge clk_sys_i);
    shutdown_pin_i <= 1'b0;
    ss_at_mid_i    <= 1'b0;
    rails_low_i    <= 1'b0;
    wait_for(S_ON, 1'b0, 8, n);
    chk(power_stage_on_o, 1'b0);
    @(posedge clk_sys_i);
    shutdown_pin_i <= 1'b1;
    wait_for(S_ON, 1'b1, 20, n);
    tick(70);
    chk(ss_ramp_o, 1'b0);
    chk(discharge_o, 1'b1);
    @(posedge clk_sys_i);
    rails_low_i <= 1'b1;
    wait_for(S_RAMP, 1'b1, 10, n);
    chk(ss_ramp_o, 1'b1);
    @(posedge clk_sys_i);
    shutdown_pin_i <= 1'b0;
    wait_for(S_ON, 1'b0, 8, n);
    chk({power_stage_on_o, ss_ramp_o}, 2'b00);
    @(posedge clk_sys_i);
    shutdown_pin_i <= 1'b1;
    uvlo_ok_i      <= 1'b0;
    tick(20);
    chk(power_stage_on_o, 1'b0);
    @(posedge clk_sys_i);
    uvlo_ok_i <= 1'b1;
    wait_for(S_ON, 1'b1, 20, n);
    chk(power_stage_on_o, 1'b1);
    $display("test long discharge and aborts done");
    end_sim();
  end
endmodule : tec_power_stage_sequencer_tb
